/* File: hw/flash_erase_regs.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by both ends of the erase interlock link
`ifndef FLASH_ERASE_REGS_SVH
`define FLASH_ERASE_REGS_SVH
// device register selects on the link (word index)
`define REG_MCR          2'h0
`define REG_CTL          2'h1
// module_config_reg fields
`define MCR_PROT_LSB     0
`define MCR_SHADOW_BIT   8
`define MCR_FUSE_LSB     16
`define MCR_RESET        32'h0000_00ff
// flash_control_reg fields
`define CTL_HVEN_BIT     0
`define CTL_SES_BIT      1
`define CTL_ERASE_BIT    2
`define CTL_GDB_BIT      3
`define CTL_NVR_BIT      4
`define CTL_PULSE_AMPLITUDE_FIELD_LSB     5
`define CTL_SCLK_LSB     8
`define CTL_HVS_BIT      11
`define CTL_BLOCK_LSB    16
`define CTL_RESET        32'h0000_0000
`define CTL_HVEN_MASK    32'h0000_0001
`define CTL_LOCK_MASK    32'h0000_00f0
`define FUSE_RESET       8'hff
// access timing in clocks
`define ON_PAGE_CLKS     5'h01
`define OFF_PAGE_CLKS    5'h02
`define MARGIN_CLKS      5'h11
// block geometry: 16k-word (64 kbyte) blocks, 32-bit words
`define BLOCK_ADDR_LSB   14
// controller APB offsets
`define APB_CMD          12'h000
`define APB_ADDR         12'h004
`define APB_WDATA        12'h008
`define APB_RDATA        12'h00c
`define APB_STATUS       12'h010
`endif

/* File: hw/flash_erase_pkg.sv */
// shared types for the erase interlock sequencer and its host controller
// assumes no imports; used as flash_erase_pkg::name
package flash_erase_pkg;
   typedef enum logic [2:0] {
      ST_NORMAL,
      ST_INTERLOCK,
      ST_HV_WRITE,
      ST_ERASE,
      ST_MARGIN
   } erase_state_t;
   typedef enum logic [1:0] {
      ACC_ARRAY_RD,
      ACC_ARRAY_WR,
      ACC_REG_RD,
      ACC_REG_WR
   } access_kind_t;
endpackage : flash_erase_pkg

/* File: hw/flash_link_if.sv */
// link between the flash module and the host controller
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface flash_link_if;
   logic                             req;
   flash_erase_pkg::access_kind_t    kind;
   logic [16:0]                      addr;
   logic [31:0]                      wdata;
   logic                             done;
   logic                             bus_err;
   logic [31:0]                      rdata;
   logic                             data_valid;
   modport device (input req, kind, addr, wdata, output done, bus_err, rdata, data_valid);
   modport host   (output req, kind, addr, wdata, input done, bus_err, rdata, data_valid);
endinterface : flash_link_if

/* File: hw/flash_module.sv */
// flash module erase interlock sequencer with a small array model
// assumes the host holds a request until done; master reset is reset_n_i
`timescale 1ns/1ps
`include "flash_erase_regs.svh"
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - erase and ses written 1 enters interlock
// - interlock wait ignores setting hv enable
// - eight 16k blocks, protected ones never erased
// - hv write state: margin reads, ehv=1 erases
// - config write in hv write state: next hv pulse clears fuses, reads then return fuses
// - hv status high locks nvr and pulse_amplitude_field
// - ses 0 in interlock, hv write or margin, or reset, returns to normal
// - erase applies hv if an unprotected block is selected, timer runs if scaling nonzero
// - array bus error during pulse, ctl ehv only
// - erase leaves on reset, or to margin
// - margin reads show erased bits, ehv returns
// - margin reads need ses and interlock write
// - unerased words read their stored data, erased read 1
// - off-page margin read takes 17 clocks
// - shadow words erased with block 0
// - shadow select blocks normal array access
// - host steps amplitude schedule, 100 ms pulses
// - host keeps gate drive bit 0
// - host verifies after each top-voltage pulse
// - emulation terminates array access, no data
// - master reset wins, registers to reset
// - reset with hv on drops hv safely
// - no interrupts, status polled only
module flash_module #(
   parameter int unsigned PULSE_MS    = 100,
   parameter int unsigned CLK_PER_MS  = 100000,
   parameter int unsigned WORDS_PER_BLOCK = 16
) (
   input  wire logic   clock_i,
   input  wire logic   reset_n_i,
   input  wire logic   emulation_i,
   output logic        high_voltage_o,
   flash_link_if.device link
);
   localparam int unsigned PULSE_CLKS = PULSE_MS * CLK_PER_MS;
   localparam int unsigned WIDX = $clog2(WORDS_PER_BLOCK);
   //////////////////////////////////////////////////////////////////////////
   flash_erase_pkg::erase_state_t state_q, state_d;
   logic [31:0] mcr_q, ctl_q;
   logic [7:0]  fuse_q;
   logic        fuse_wr_q;
   logic        hvs_q;
   logic [31:0] timer_q;
   logic [4:0]  wait_q;
   logic        busy_q;
   logic [16:0] page_q;
   logic        page_ok_q;
   logic        done_q, err_q, dv_q;
   logic [31:0] rdata_q;
   logic        hv_q;
   logic [31:0] mem_q [8][WORDS_PER_BLOCK];
   logic [31:0] shadow_q;
   logic        emu_s1_q, emu_s2_q, emu_s3_q, emu_q;
   // request decode
   wire take      = link.req & ~busy_q & ~done_q;
   wire is_arr_rd = link.kind == flash_erase_pkg::ACC_ARRAY_RD;
   wire is_arr_wr = link.kind == flash_erase_pkg::ACC_ARRAY_WR;
   wire is_reg_wr = link.kind == flash_erase_pkg::ACC_REG_WR;
   wire is_arr    = is_arr_rd | is_arr_wr;
   wire sel_mcr   = link.addr[1:0] == `REG_MCR;
   wire sel_ctl   = link.addr[1:0] == `REG_CTL;
   wire ctl_wr    = take & is_reg_wr & sel_ctl;
   wire mcr_wr    = take & is_reg_wr & sel_mcr;
   wire shadow_on = mcr_q[`MCR_SHADOW_BIT];
   wire erase_enable_select       = ctl_q[`CTL_SES_BIT];
   wire new_hven  = link.wdata[`CTL_HVEN_BIT];
   wire [2:0] blk = link.addr[16:14];
   wire [WIDX-1:0] widx = link.addr[WIDX-1:0];
   wire in_erase  = state_q == flash_erase_pkg::ST_ERASE;
   wire margin_en = erase_enable_select & (state_q == flash_erase_pkg::ST_HV_WRITE
                          || state_q == flash_erase_pkg::ST_MARGIN);
   wire off_page  = link.addr[16:2] != page_q[16:2] | ~page_ok_q;
   wire arr_block = in_erase | (shadow_on & ~margin_en);
   wire [4:0] rd_clks = off_page ? (margin_en ? `MARGIN_CLKS : `OFF_PAGE_CLKS)
                                 : `ON_PAGE_CLKS;
   wire one_clk   = rd_clks == `ON_PAGE_CLKS;
   wire [7:0] erase_mask = ctl_q[`CTL_BLOCK_LSB +: 8] & ~mcr_q[`MCR_PROT_LSB +: 8];
   wire timer_run = ctl_q[`CTL_SCLK_LSB +: 3] != 3'h0;
   // locked fields keep their value once hv status rises
   wire [31:0] ctl_mask = in_erase ? `CTL_HVEN_MASK
                        : hvs_q ? ~`CTL_LOCK_MASK
                        : 32'hffff_ffff;
   wire [31:0] ctl_wv = (ctl_q & ~ctl_mask) | (link.wdata & ctl_mask);
   //////////////////////////////////////////////////////////////////////////
   // emulation pin: three flops, a change counts once the last two agree
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         {emu_s1_q, emu_s2_q, emu_s3_q, emu_q} <= 4'h0;
      end else begin
         emu_s1_q <= emulation_i;
         emu_s2_q <= emu_s1_q;
         emu_s3_q <= emu_s2_q;
         if (emu_s2_q == emu_s3_q) emu_q <= emu_s3_q;
      end
   end
   // interlock state machine
   always_comb begin
      state_d = state_q;
      case (state_q)
         flash_erase_pkg::ST_NORMAL:
            if (ctl_wr && link.wdata[`CTL_ERASE_BIT] && link.wdata[`CTL_SES_BIT]) begin
               state_d = flash_erase_pkg::ST_INTERLOCK;
            end
         flash_erase_pkg::ST_INTERLOCK:
            if (ctl_wr && !link.wdata[`CTL_SES_BIT]) begin
               state_d = flash_erase_pkg::ST_NORMAL;
            end else if ((take && is_arr_wr && !emu_q) || mcr_wr) begin
               state_d = flash_erase_pkg::ST_HV_WRITE;
            end
         flash_erase_pkg::ST_HV_WRITE, flash_erase_pkg::ST_MARGIN:
            if (ctl_wr && !link.wdata[`CTL_SES_BIT]) begin
               state_d = flash_erase_pkg::ST_NORMAL;
            end else if (ctl_wr && new_hven) begin
               state_d = flash_erase_pkg::ST_ERASE;
            end
         flash_erase_pkg::ST_ERASE:
            if (!ctl_q[`CTL_HVEN_BIT] && !hvs_q) begin
               state_d = flash_erase_pkg::ST_MARGIN;
            end
         default: state_d = flash_erase_pkg::ST_NORMAL;
      endcase
   end
   // state, registers, timer; synchronous reset wins over all
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         state_q   <= flash_erase_pkg::ST_NORMAL;
         mcr_q     <= `MCR_RESET;
         ctl_q     <= `CTL_RESET;
         hvs_q     <= 1'b0;
         hv_q      <= 1'b0;
         timer_q   <= 32'h0;
         fuse_wr_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (mcr_wr && !in_erase) begin
            mcr_q <= link.wdata;
         end
         if (mcr_wr && state_q == flash_erase_pkg::ST_HV_WRITE) begin
            fuse_wr_q <= 1'b1;
         end
         if (ctl_wr) begin
            // interlock wait refuses to set hv enable
            ctl_q <= (state_q == flash_erase_pkg::ST_INTERLOCK || state_q == flash_erase_pkg::ST_NORMAL)
                     ? (ctl_wv & ~`CTL_HVEN_MASK) : ctl_wv;
         end
         if (state_d == flash_erase_pkg::ST_ERASE && !in_erase) begin
            hvs_q   <= 1'b1;
            hv_q    <= |erase_mask;
            timer_q <= PULSE_CLKS;
         end else if (in_erase && hvs_q) begin
            if (!ctl_q[`CTL_HVEN_BIT] || (timer_run && timer_q == 32'h1)) begin
               hvs_q <= 1'b0;
               hv_q  <= 1'b0;
            end else if (timer_run) begin
               timer_q <= timer_q - 32'h1;
            end
         end
      end
   end
   // fuses: cleared as soon as a pulse applies hv if config was written
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         fuse_q <= `FUSE_RESET;
      end else if (fuse_wr_q && in_erase && hvs_q && hv_q) begin
         fuse_q <= 8'h00;
      end
   end
   // array: erase sets selected words to all ones each pulse
   genvar gb;
   for (gb = 0; gb < 8; gb++) begin : g_blk
      always_ff @(posedge clock_i) begin
         if (in_erase && hv_q && erase_mask[gb]) begin
            for (int w = 0; w < WORDS_PER_BLOCK; w++) begin
               mem_q[gb][w] <= 32'hffff_ffff;
            end
         end else if (take && is_arr_wr && !arr_block && !emu_q
                      && blk == gb && state_q == flash_erase_pkg::ST_NORMAL) begin
            // plain store: the model array starts unknown, so no and-in
            mem_q[gb][widx] <= link.wdata;
         end
      end
   end
   always_ff @(posedge clock_i) begin
      if (in_erase && hv_q && erase_mask[0]) begin
         shadow_q <= 32'hffff_ffff;
      end
   end
   // access timing and answer
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         busy_q <= 1'b0;
         wait_q <= 5'h0;
         done_q <= 1'b0;
         err_q  <= 1'b0;
         dv_q   <= 1'b0;
         rdata_q <= 32'h0;
         page_q <= 17'h0;
         page_ok_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         err_q  <= 1'b0;
         dv_q   <= 1'b0;
         if (take) begin
            if (is_arr && arr_block) begin
               done_q <= 1'b1;
               err_q  <= 1'b1;
            end else if (is_arr_rd) begin
               // one-clock reads answer like registers, longer ones count down
               busy_q <= ~one_clk;
               done_q <= one_clk;
               dv_q   <= one_clk & ~emu_q;
               wait_q <= rd_clks - 5'h2;
               page_q <= link.addr;
               page_ok_q <= 1'b1;
               if (emu_q) begin
                  rdata_q <= 32'h0;
               end else begin
                  rdata_q <= shadow_on ? shadow_q : mem_q[blk][widx];
               end
            end else begin
               done_q <= 1'b1;
               dv_q   <= ~is_arr & ~is_reg_wr;
               rdata_q <= sel_ctl ? (ctl_q | ({31'h0, hvs_q} << `CTL_HVS_BIT))
                        : (fuse_wr_q ? {mcr_q[31:24], fuse_q, mcr_q[15:0]} : mcr_q);
            end
         end else if (busy_q) begin
            if (wait_q == 5'h0) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
               dv_q   <= ~emu_q;
            end else begin
               wait_q <= wait_q - 5'h1;
            end
         end
      end
   end
   // outputs from flops; no interrupt output exists
   assign link.done       = done_q;
   assign link.bus_err    = err_q;
   assign link.rdata      = rdata_q;
   assign link.data_valid = dv_q;
   assign high_voltage_o  = hv_q;
endmodule : flash_module

/* File: hw/flash_host.sv */
// host controller: APB slave registers drive single link accesses
// assumes software runs the erase algorithm through these registers
`timescale 1ns/1ps
`include "flash_erase_regs.svh"
module flash_host (
   input  wire logic   clock_i,
   input  wire logic   reset_n_i,
   input  wire logic   psel_i,
   input  wire logic   penable_i,
   input  wire logic   pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic        pready_o,
   output logic [31:0] prdata_o,
   output logic        pslverr_o,
   flash_link_if.host  link
);
   logic        req_q, busy_q, err_q, pready_q, pslverr_q;
   logic [1:0]  kind_q;
   logic [16:0] addr_q;
   logic [31:0] wdata_q, rdata_q, prdata_q;
   //////////////////////////////////////////////////////////////////////////
   // apb decode; software keeps gdb 0 and steps pulse_amplitude_field/nvr itself
   wire setup   = psel_i & ~penable_i;
   // writes land at the access edge where pready is seen, not at setup
   wire acc_edge = psel_i & penable_i & pready_q;
   wire wr      = acc_edge & pwrite_i;
   wire hit_cmd = paddr_i == `APB_CMD;
   wire hit_ok  = hit_cmd | paddr_i == `APB_ADDR | paddr_i == `APB_WDATA
                | paddr_i == `APB_RDATA | paddr_i == `APB_STATUS;
   wire [31:0] rd_mux = paddr_i == `APB_ADDR   ? {15'h0, addr_q}
                      : paddr_i == `APB_WDATA  ? wdata_q
                      : paddr_i == `APB_RDATA  ? rdata_q
                      : paddr_i == `APB_STATUS ? {30'h0, err_q, busy_q}
                      : {30'h0, kind_q};
   // apb answers one cycle after setup
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~hit_ok;
         prdata_q  <= setup ? rd_mux : 32'h0;
      end
   end
   // register writes and link request; command write while busy is dropped
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         req_q   <= 1'b0;
         busy_q  <= 1'b0;
         err_q   <= 1'b0;
         kind_q  <= 2'h0;
         addr_q  <= 17'h0;
         wdata_q <= 32'h0;
         rdata_q <= 32'h0;
      end else begin
         if (wr && paddr_i == `APB_ADDR) addr_q <= pwdata_i[16:0];
         if (wr && paddr_i == `APB_WDATA) wdata_q <= pwdata_i;
         if (wr && hit_cmd && !busy_q) begin
            kind_q <= pwdata_i[1:0];
            req_q  <= 1'b1;
            busy_q <= 1'b1;
         end else if (link.done) begin
            req_q  <= 1'b0;
            busy_q <= 1'b0;
            err_q  <= link.bus_err;
            if (link.data_valid) rdata_q <= link.rdata;
         end
      end
   end
   assign link.req   = req_q;
   assign link.kind  = flash_erase_pkg::access_kind_t'(kind_q);
   assign link.addr  = addr_q;
   assign link.wdata = wdata_q;
   assign pready_o   = pready_q;
   assign pslverr_o  = pslverr_q;
   assign prdata_o   = prdata_q;
endmodule : flash_host

/* File: sim/flash_erase_interlock_props.sv */
// concurrent checks on the erase interlock link between host and flash module
// assumes the bench top instantiates it beside the link interface
`timescale 1ns/1ps
module flash_erase_interlock_props (
   input wire logic                     clock_i,
   input wire logic                     reset_n_i,
   input wire logic                     req,
   input flash_erase_pkg::access_kind_t kind,
   input wire logic                     done,
   input wire logic                     bus_err,
   input wire logic                     data_valid,
   input wire logic                     high_voltage_o
);
   // one clock domain, so one clocking and one disable serve all checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   wire reg_kind = kind == flash_erase_pkg::ACC_REG_RD || kind == flash_erase_pkg::ACC_REG_WR;
   //////////////////////////////////////////////////////////////////////////////
   // handshake shape; kind[1] marks the two register kinds
   done_pulse_a: assert property (done |=> !done) else $error("done held over two cycles");
   err_done_a: assert property (bus_err |-> done) else $error("bus error without done");
   valid_done_a: assert property (data_valid |-> done) else $error("data valid without done");
   reg_fast_a: assert property ($rose(req) && reg_kind |=> done) else $error("register access slow");
   reg_no_err_a: assert property (done && reg_kind |-> !bus_err) else $error("register access refused");
   arr_bound_a: assert property ($rose(req) |-> ##[1:17] done) else $error("access over 17 clocks");
   req_hold_a: assert property (req && !done |=> req && $stable(kind)) else $error("request dropped early");
   hv_reset_a: assert property ($rose(reset_n_i) |-> !high_voltage_o) else $error("hv on after reset");
   reg_read_a: assert property (done && kind == flash_erase_pkg::ACC_REG_RD |-> data_valid)
      else $error("register read without data");
   // main scenarios: margin read, refused access, erase pulse
   cover property ($rose(req) ##17 done);
   cover property (bus_err);
   cover property ($rose(high_voltage_o));
endmodule : flash_erase_interlock_props

/* File: sim/flash_erase_interlock_tb.sv */
// self-checking bench: APB master drives the host, which drives the flash module
// assumes the pulse is shortened with CLK_PER_MS set to 10 clocks
`timescale 1ns/1ps
`include "flash_erase_regs.svh"
module flash_erase_interlock_tb;
   logic        clock_i, reset_n_i, emulation_i, high_voltage_o;
   logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e, sv, dv;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, r, d, seed;
   logic [16:0] a0, a1;
   int          miscompares = 0, n_checks = 0, cyc = 0, lat = 0, last = 0;
   // erase=ses=1, blocks 0-1, sclk 1, pulse_amplitude_field 111, nvr 1, gdb 0
   localparam logic [31:0] CB = 32'h0003_01f6;
   flash_link_if link();
   flash_module #(.CLK_PER_MS(10)) flash_module_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .emulation_i(emulation_i), .high_voltage_o(high_voltage_o), .link(link));
   flash_host flash_host_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
      .pslverr_o(pslverr_o), .link(link));
   flash_erase_interlock_props flash_erase_interlock_props_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .req(link.req), .kind(link.kind), .done(link.done), .bus_err(link.bus_err), .data_valid(link.data_valid),
      .high_voltage_o(high_voltage_o));
   always #5 clock_i = ~clock_i;
   //////////////////////////////////////////////////////////////////////////////
   // latency monitor on the link, plus the hang guard
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (!link.req) lat <= 0;
      else if (!link.done) lat <= lat + 1;
      if (link.done) begin
         last <= lat;
         dv <= link.data_valid;
      end
      if (cyc == 60000) begin
         miscompares++;
         give_verdict();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, x, s);
      end
   endtask : chk
   // one APB transfer; an idle edge first keeps drivers single per step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clock_i);
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, 1'b0, w, a, wd};
      @(posedge clock_i);
      penable_i <= 1'b1;
      // waits for pready; only the bench timeout ends a wait that never sees it
      do begin
         @(posedge clock_i);
      end while (pready_o !== 1'b1);
      r = prdata_o;
      sv = pslverr_o;
      {psel_i, penable_i} <= 2'b00;
   endtask : apb
   // one link access through the host, polled to completion
   task automatic lop(input flash_erase_pkg::access_kind_t k, input logic [16:0] a, input logic [31:0] wd);
      apb(1'b1, `APB_ADDR, {15'h0, a});
      apb(1'b1, `APB_WDATA, wd);
      apb(1'b1, `APB_CMD, {30'h0, k});
      do begin
         apb(1'b0, `APB_STATUS, 32'h0);
      end while (r[0] !== 1'b0);
      e = r[1];
      apb(1'b0, `APB_RDATA, 32'h0);
   endtask : lop
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   //////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {clock_i, reset_n_i, emulation_i, psel_i, penable_i, pwrite_i} = 6'h0;
      {paddr_i, pwdata_i} = '0;
      seed = lfsr(32'h4a7aa000);
      d = {seed[31:1], 1'b0};
      a0 = {13'h0, seed[3:0]};
      a1 = {3'h1, 10'h0, seed[7:4]};
      repeat (2) @(posedge clock_i);
      reset_n_i <= 1'b1;
      lop(flash_erase_pkg::ACC_REG_RD, 17'h0, 32'h0);
      chk("mcr_reset", r, `MCR_RESET);
      lop(flash_erase_pkg::ACC_REG_RD, 17'h1, 32'h0);
      chk("ctl_reset", r, `CTL_RESET);
      apb(1'b0, 12'h0f0, 32'h0);
      chk("unmapped_err", sv, 1);
      lop(flash_erase_pkg::ACC_ARRAY_WR, a0, d);
      lop(flash_erase_pkg::ACC_ARRAY_WR, a1, d);
      lop(flash_erase_pkg::ACC_ARRAY_RD, a0, 32'h0);
      chk("normal_rd", r, d);
      chk("normal_lat", last, 2);
      lop(flash_erase_pkg::ACC_REG_WR, 17'h0, 32'h0000_00fe);
      $display("normal access done");
      // erase: interlock, ignored hv enable, pulse, locks, expiry
      lop(flash_erase_pkg::ACC_REG_WR, 17'h1, CB);
      lop(flash_erase_pkg::ACC_REG_WR, 17'h1, CB | 32'h1);
      lop(flash_erase_pkg::ACC_REG_RD, 17'h1, 32'h0);
      chk("hven_ignored", r[0], 0);
      lop(flash_erase_pkg::ACC_ARRAY_WR, a0, 32'h0);
      lop(flash_erase_pkg::ACC_ARRAY_RD, a1, 32'h0);
      chk("margin_lat", last, 17);
      lop(flash_erase_pkg::ACC_REG_WR, 17'h1, CB | 32'h1);
      chk("hv_on", high_voltage_o, 1);
      lop(flash_erase_pkg::ACC_ARRAY_RD, a0, 32'h0);
      chk("pulse_arr_err", e, 1);
      lop(flash_erase_pkg::ACC_REG_WR, 17'h1, CB & 32'hffff_ffef | 32'h1);
      lop(flash_erase_pkg::ACC_REG_RD, 17'h1, 32'h0);
      chk("hvs_set", r[11], 1);
      chk("nvr_locked", r[4], 1);
      for (int n = 0; n < 200 && r[11] !== 1'b0; n++) lop(flash_erase_pkg::ACC_REG_RD, 17'h1, 32'h0);
      chk("hv_expired", high_voltage_o, 0);
      lop(flash_erase_pkg::ACC_REG_WR, 17'h1, CB);
      lop(flash_erase_pkg::ACC_ARRAY_RD, a1, 32'h0);
      chk("protected_kept", r, d);
      lop(flash_erase_pkg::ACC_ARRAY_RD, a0, 32'h0);
      chk("erased_ones", r, 32'hffff_ffff);
      chk("margin_lat2", last, 17);
      lop(flash_erase_pkg::ACC_REG_WR, 17'h1, CB & 32'hffff_fffd);
      lop(flash_erase_pkg::ACC_ARRAY_RD, a1, 32'h0);
      chk("normal_again", last, 2);
      $display("erase pulse done");
      // second erase, cut short by master reset mid-pulse
      lop(flash_erase_pkg::ACC_REG_WR, 17'h1, CB);
      lop(flash_erase_pkg::ACC_ARRAY_WR, a0, 32'h0);
      lop(flash_erase_pkg::ACC_REG_WR, 17'h0, 32'h00ff_00fe);
      lop(flash_erase_pkg::ACC_REG_WR, 17'h1, CB | 32'h1);
      lop(flash_erase_pkg::ACC_REG_RD, 17'h0, 32'h0);
      chk("fuse_cleared", r, 32'h0000_00fe);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      reset_n_i <= 1'b1;
      @(posedge clock_i);
      chk("reset_hv_off", high_voltage_o, 0);
      lop(flash_erase_pkg::ACC_REG_RD, 17'h1, 32'h0);
      chk("reset_ctl", r, `CTL_RESET);
      // shadow select refuses array, clearing restores it
      lop(flash_erase_pkg::ACC_REG_WR, 17'h0, 32'h0000_01ff);
      lop(flash_erase_pkg::ACC_ARRAY_RD, a0, 32'h0);
      chk("shadow_err", e, 1);
      lop(flash_erase_pkg::ACC_REG_WR, 17'h0, `MCR_RESET);
      lop(flash_erase_pkg::ACC_ARRAY_RD, a0, 32'h0);
      chk("shadow_clear", e, 0);
      emulation_i <= 1'b1;
      lop(flash_erase_pkg::ACC_ARRAY_RD, a1, 32'h0);
      chk("emu_no_data", dv, 0);
      chk("emu_lat", last, 2);
      emulation_i <= 1'b0;
      $display("reset and modes done");
      give_verdict();
   end
endmodule : flash_erase_interlock_tb
